// [nested_vector_irq_ctrl.sv]
// interrupt pending/active tracking and priority arbitration front end
// assumes core entry/exit strobes and software writes are on CLK_I
`timescale 1ns/100ps
module nested_vector_irq_ctrl
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // peripheral request lines
  input wire logic [irq_pkg::NUM_IRQ-1:0] IRQ_LINE_I,
  input wire logic NMI_LINE_I,
  // configuration
  input wire logic [irq_pkg::NUM_IRQ-1:0] PULSE_MODE_I,
  input wire logic [irq_pkg::NUM_IRQ*irq_pkg::PRIO_W-1:0] PRIO_I,
  input wire logic [irq_pkg::GROUP_SEL_W-1:0] SUBPRIO_BITS_I,
  input wire logic [irq_pkg::NUM_IRQ-1:0] ENABLE_I,
  // software pending control
  input wire logic [irq_pkg::NUM_IRQ-1:0] SET_PEND_I,
  input wire logic [irq_pkg::NUM_IRQ-1:0] CLR_PEND_I,
  input wire logic SOFT_TRIG_WR_I,
  input wire logic [irq_pkg::IDX_W-1:0] SOFT_TRIG_IDX_I,
  // core service routine handshake
  input wire logic ENTER_I,
  input wire logic [irq_pkg::VEC_W-1:0] ENTER_VEC_I,
  input wire logic EXIT_I,
  input wire logic [irq_pkg::VEC_W-1:0] EXIT_VEC_I,
  // status and request to core
  output logic [irq_pkg::NUM_IRQ-1:0] PENDING_O,
  output logic [irq_pkg::NUM_IRQ-1:0] ACTIVE_O,
  output logic REQ_O,
  output logic [irq_pkg::VEC_W-1:0] REQ_VEC_O,
  output logic [irq_pkg::PRIO_W-1:0] REQ_PRIO_O,
  output logic NMI_PEND_O,
  output logic NMI_ACTIVE_O
);
  import irq_pkg::*;

  // three-stage input synchronisers
  logic [NUM_IRQ-1:0] s1_q, s2_q, s3_q;
  logic nmi1_q, nmi2_q, nmi3_q;
  logic [NUM_IRQ-1:0] s1_d, s2_d, s3_d;
  logic nmi1_d, nmi2_d, nmi3_d;
  logic [NUM_IRQ-1:0] level_hi, edge_hi;
  logic nmi_edge;

  always_comb
  begin
    s1_d = IRQ_LINE_I;
    s2_d = s1_q;
    s3_d = s2_q;
    nmi1_d = NMI_LINE_I;
    nmi2_d = nmi1_q;
    nmi3_d = nmi2_q;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      nmi1_q <= 1'b0;
      nmi2_q <= 1'b0;
      nmi3_q <= 1'b0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      nmi1_q <= nmi1_d;
      nmi2_q <= nmi2_d;
      nmi3_q <= nmi3_d;
    end
  end

  // level seen when stages two and three are both high; edge when stage two is high and stage three still low
  assign level_hi = s2_q & s3_q;
  assign edge_hi = s2_q & ~s3_q;
  assign nmi_edge = nmi2_q & ~nmi3_q;

  // per-interrupt state
  irq_state_type st_q [NUM_IRQ];
  irq_state_type st_d [NUM_IRQ];
  logic nmi_pend_q, nmi_act_q, nmi_pend_d, nmi_act_d;

  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++)
    begin : g_irq
      logic enter_me, exit_me, sw_set, pend, act;
      logic [VEC_W-1:0] my_vec;
      assign my_vec = VEC_W'(VEC_IRQ_BASE + VEC_W'(g));
      assign enter_me = ENTER_I && (ENTER_VEC_I == my_vec);
      assign exit_me = EXIT_I && (EXIT_VEC_I == my_vec);
      assign sw_set = SET_PEND_I[g] ||
        (SOFT_TRIG_WR_I && (SOFT_TRIG_IDX_I == IDX_W'(g)));

      always_comb
      begin
        pend = st_q[g][ST_PEND];
        act = st_q[g][ST_ACT];
        if (enter_me)
        begin
          pend = 1'b0;
          act = 1'b1;
        end
        else if (exit_me)
        begin
          act = 1'b0;
          if (PULSE_MODE_I[g])
            pend = pend;
          else
            pend = level_hi[g];
        end
        if (CLR_PEND_I[g])
        begin
          if (PULSE_MODE_I[g])
            pend = 1'b0;
          else if (!level_hi[g])
          begin
            pend = 1'b0;
            act = 1'b0;
          end
        end
        // hardware and software sets win over a clear in the same cycle
        if (PULSE_MODE_I[g])
        begin
          if (edge_hi[g])
            pend = 1'b1;
        end
        else if (level_hi[g] && !act)
          pend = 1'b1;
        if (sw_set)
          pend = 1'b1;
        st_d[g] = irq_state_type'({act, pend});
      end

      always_ff @(posedge CLK_I)
      begin
        if (SRST_I)
          st_q[g] <= IRQ_INACTIVE;
        else
          st_q[g] <= st_d[g];
      end

      assign PENDING_O[g] = st_q[g][ST_PEND];
      assign ACTIVE_O[g] = st_q[g][ST_ACT];
    end
  endgenerate

  // non-maskable line: edge latched, ignores enables
  always_comb
  begin
    nmi_pend_d = nmi_pend_q;
    nmi_act_d = nmi_act_q;
    if (ENTER_I && ENTER_VEC_I == VEC_NMI)
    begin
      nmi_pend_d = 1'b0;
      nmi_act_d = 1'b1;
    end
    else if (EXIT_I && EXIT_VEC_I == VEC_NMI)
      nmi_act_d = 1'b0;
    if (nmi_edge)
      nmi_pend_d = 1'b1;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      nmi_pend_q <= 1'b0;
      nmi_act_q <= 1'b0;
    end
    else
    begin
      nmi_pend_q <= nmi_pend_d;
      nmi_act_q <= nmi_act_d;
    end
  end

  assign NMI_PEND_O = nmi_pend_q;
  assign NMI_ACTIVE_O = nmi_act_q;

  // arbitration: lowest level wins, group part first, then subpriority,
  // then lowest index; pending must beat the running group priority
  logic [PRIO_W-1:0] grp_mask;
  logic [PRIO_W:0] run_grp;
  logic [PRIO_W:0] best_p;
  logic [IDX_W-1:0] best_i;
  logic found;
  logic [PRIO_W-1:0] p;

  always_comb
  begin
    grp_mask = PRIO_W'({PRIO_W{1'b1}} << SUBPRIO_BITS_I);
    run_grp = PRIO_IDLE;
    best_p = PRIO_IDLE;
    best_i = '0;
    found = 1'b0;
    p = '0;
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      p = PRIO_I[i*PRIO_W +: PRIO_W];
      if (st_q[i][ST_ACT] && {1'b0, p & grp_mask} < run_grp)
        run_grp = {1'b0, p & grp_mask};
    end
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      p = PRIO_I[i*PRIO_W +: PRIO_W];
      if (st_q[i][ST_PEND] && ENABLE_I[i] && !st_q[i][ST_ACT] &&
          {1'b0, p & grp_mask} < run_grp && {1'b0, p} < best_p)
      begin
        best_p = {1'b0, p};
        best_i = IDX_W'(i);
        found = 1'b1;
      end
    end
  end

  logic req_q, req_d;
  logic [VEC_W-1:0] vec_q, vec_d;
  logic [PRIO_W-1:0] rprio_q, rprio_d;

  // nmi outranks every maskable line; core saves context itself
  always_comb
  begin
    req_d = 1'b0;
    vec_d = VEC_NONE;
    rprio_d = '0;
    if (nmi_pend_q && !nmi_act_q)
    begin
      req_d = 1'b1;
      vec_d = VEC_NMI;
    end
    else if (found && !nmi_act_q)
    begin
      req_d = 1'b1;
      vec_d = VEC_W'(VEC_IRQ_BASE + VEC_W'(best_i));
      rprio_d = best_p[PRIO_W-1:0];
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      req_q <= 1'b0;
      vec_q <= VEC_NONE;
      rprio_q <= '0;
    end
    else
    begin
      req_q <= req_d;
      vec_q <= vec_d;
      rprio_q <= rprio_d;
    end
  end

  assign REQ_O = req_q;
  assign REQ_VEC_O = vec_q;
  assign REQ_PRIO_O = rprio_q;
endmodule

// [irq_pkg.sv]
// constants, types and state encodings for the interrupt pending logic
// assumes a single 40 MHz processor clock and synchronous reset
// Contract
// - thirty peripheral interrupt inputs, each with a priority level 0 to 7.
// - numerically lower priority level wins; level 0 is most urgent.
// - priority splits into group part and subpriority part for arbitration.
// - each input is configured as level-sensitive or pulse request.
// - one extra non-maskable interrupt input that software cannot mask.
// - core stacks state on entry and unstacks on exit without instructions.
// - pulse inputs sampled on rising clock edge; detected pulse is latched.
// - high input while not active makes the interrupt pending.
// - rising edge on input makes the interrupt pending.
// - software set-pending or soft trigger makes the interrupt pending.
// - service entry clears pending and marks the interrupt active.
// - level return: pending if input still high, otherwise inactive.
// - pulse during active gives active-and-pending; return gives pending.
// - pulse return without new pulse makes the interrupt inactive.
// - level clear-pending: unchanged while input high, otherwise inactive.
// - pulse clear-pending: pending to inactive, active-pending to active.
package irq_pkg;
  localparam int NUM_IRQ = 30;
  localparam int IDX_W = 5;
  localparam int PRIO_W = 3;
  localparam int GROUP_SEL_W = 2;
  localparam int VEC_W = 6;
  localparam logic [VEC_W-1:0] VEC_NONE = 6'h00;
  localparam logic [VEC_W-1:0] VEC_NMI = 6'h02;
  localparam logic [VEC_W-1:0] VEC_IRQ_BASE = 6'h10;
  localparam logic [PRIO_W:0] PRIO_IDLE = 4'h8;
  localparam int ST_PEND = 0;
  localparam int ST_ACT = 1;
  typedef enum logic [1:0] {
    IRQ_INACTIVE = 2'b00,
    IRQ_PENDING = 2'b01,
    IRQ_ACTIVE = 2'b10,
    IRQ_ACT_PEND = 2'b11
  } irq_state_type;
endpackage

// [irq_ctrl_monitor.sv]
// checker on the pending logic ports
// bound into every controller instance
`timescale 1ns/100ps
module irq_ctrl_monitor
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [29:0] IRQ_LINE_I,
  input wire logic NMI_LINE_I,
  input wire logic [29:0] PULSE_MODE_I,
  input wire logic [29:0] SET_PEND_I,
  input wire logic [29:0] CLR_PEND_I,
  input wire logic ENTER_I,
  input wire logic [5:0] ENTER_VEC_I,
  input wire logic EXIT_I,
  input wire logic [5:0] EXIT_VEC_I,
  input wire logic [29:0] PENDING_O,
  input wire logic [29:0] ACTIVE_O,
  input wire logic NMI_PEND_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  sequence s_hi0; IRQ_LINE_I[0] [*6]; endsequence
  sequence s_lo0; !IRQ_LINE_I[0] [*6]; endsequence
  sequence s_lo1; !IRQ_LINE_I[1] [*5]; endsequence
  sequence s_nmi; !NMI_LINE_I [*2] ##1 NMI_LINE_I [*4]; endsequence
  property p_rst;
    disable iff (1'b0) SRST_I |=> !PENDING_O && !ACTIVE_O;
  endproperty
  property p_set; SET_PEND_I[2] |=> PENDING_O[2]; endproperty
  property p_edge;
    PULSE_MODE_I[1] && $rose(IRQ_LINE_I[1]) |-> ##[2:4] PENDING_O[1];
  endproperty
  property p_enter;
    (ENTER_I && ENTER_VEC_I == 6'h10) |=> ACTIVE_O[0] && !PENDING_O[0];
  endproperty
  property p_lexit;
    s_lo0 ##0 (EXIT_I && EXIT_VEC_I == 6'h10 && ACTIVE_O[0] &&
      !PULSE_MODE_I[0]) |=> !ACTIVE_O[0] && !PENDING_O[0];
  endproperty
  property p_lclr;
    s_hi0 ##0 (CLR_PEND_I[0] && !PULSE_MODE_I[0] && !ENTER_I && !EXIT_I)
      |=> $stable(PENDING_O[0]) && $stable(ACTIVE_O[0]);
  endproperty
  property p_pclr;
    s_lo1 ##0 (CLR_PEND_I[1] && PULSE_MODE_I[1] && ACTIVE_O[1] && !EXIT_I)
      |=> ACTIVE_O[1] && !PENDING_O[1];
  endproperty
  property p_nmi; s_nmi |-> ##[0:2] NMI_PEND_O; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  a_set: assert property (p_set) else $error("set lost");
  a_edge: assert property (p_edge) else $error("edge lost");
  a_enter: assert property (p_enter) else $error("entry");
  a_lexit: assert property (p_lexit) else $error("level exit");
  a_lclr: assert property (p_lclr) else $error("level clear");
  a_pclr: assert property (p_pclr) else $error("pulse clear");
  a_nmi: assert property (p_nmi) else $error("nmi lost");
endmodule
bind nested_vector_irq_ctrl irq_ctrl_monitor mon (.*);

// [irq_source.sv]
// peripheral model: one level source and one pulse source
// changes just after the rising edge of the bench clock
`timescale 1ns/100ps
module irq_source
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  input wire logic ack_i,
  input wire logic kick_i,
  output logic level_o,
  output logic pulse_o
);
  always_ff @(posedge clk_i)
  begin
    // level held until the routine services the source
    if (rst_i || ack_i)
      level_o <= 1'b0;
    else if (fire_i)
      level_o <= 1'b1;
    pulse_o <= kick_i && !rst_i;
  end
endmodule

// [nested_irq_pending_logic_tb.sv]
// self-checking bench for the interrupt pending logic
// irq 0 is level and irq 1 pulse, both from the source model
`timescale 1ns/100ps
module nested_irq_pending_logic_tb;
  import irq_pkg::*;
  logic CLK_I = 0, SRST_I = 1, fire = 0, ack = 0, kick = 0, lvl, pul;
  logic NMI_LINE_I = 0, SOFT_TRIG_WR_I = 0, ENTER_I = 0, EXIT_I = 0;
  logic [NUM_IRQ-1:0] PULSE_MODE_I = 30'h2, ENABLE_I = '1;
  logic [NUM_IRQ-1:0] SET_PEND_I = '0, CLR_PEND_I = '0, PENDING_O, ACTIVE_O;
  logic [NUM_IRQ*PRIO_W-1:0] PRIO_I = '1;
  logic [GROUP_SEL_W-1:0] SUBPRIO_BITS_I = '0;
  logic [IDX_W-1:0] SOFT_TRIG_IDX_I = '0;
  logic [VEC_W-1:0] ENTER_VEC_I = '0, EXIT_VEC_I = '0, REQ_VEC_O;
  logic [PRIO_W-1:0] REQ_PRIO_O;
  logic REQ_O, NMI_PEND_O, NMI_ACTIVE_O;
  int miscompares = 0, n_tests = 0, cyc = 0;
  always #12.5 CLK_I = ~CLK_I;
  irq_source src (.clk_i(CLK_I), .rst_i(SRST_I), .fire_i(fire),
    .ack_i(ack), .kick_i(kick), .level_o(lvl), .pulse_o(pul));
  nested_vector_irq_ctrl dut (.IRQ_LINE_I({28'h0, pul, lvl}), .*);
  task automatic summarize;
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge CLK_I)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      miscompares++;
      summarize;
    end
  end
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tk(int n);
    repeat (n) @(negedge CLK_I);
  endtask
  function automatic logic [1:0] st(int i);
    return {ACTIVE_O[i], PENDING_O[i]};
  endfunction
  // one-cycle core strobe: entry when in is set, else return
  task automatic core(logic in, logic [VEC_W-1:0] v);
    ENTER_VEC_I = v;
    EXIT_VEC_I = v;
    ENTER_I = in;
    EXIT_I = !in;
    tk(1);
    ENTER_I = 0;
    EXIT_I = 0;
  endtask
  task automatic clr(int i);
    CLR_PEND_I[i] = 1;
    tk(1);
    CLR_PEND_I = '0;
  endtask
  task automatic pulse1;
    kick = 1;
    tk(1);
    kick = 0;
    tk(5);
  endtask
  task automatic t_level;
    fire = 1;
    tk(1);
    fire = 0;
    tk(5);
    chk(st(0), 2'h1);
    chk({REQ_O, REQ_VEC_O}, 7'h50);
    clr(0);
    chk(st(0), 2'h1);
    core(1, 6'h10);
    chk(st(0), 2'h2);
    core(0, 6'h10);
    chk(st(0), 2'h1);
    core(1, 6'h10);
    ack = 1;
    tk(1);
    ack = 0;
    tk(5);
    core(0, 6'h10);
    chk(st(0), 2'h0);
  endtask
  task automatic t_pulse;
    pulse1;
    chk(st(1), 2'h1);
    core(1, 6'h11);
    pulse1;
    chk(st(1), 2'h3);
    core(0, 6'h11);
    chk(st(1), 2'h1);
    core(1, 6'h11);
    pulse1;
    clr(1);
    chk(st(1), 2'h2);
    core(0, 6'h11);
    chk(st(1), 2'h0);
    pulse1;
    clr(1);
    chk(st(1), 2'h0);
  endtask
  task automatic t_soft;
    PRIO_I[89:87] = 3'h0;
    PRIO_I[8:6] = 3'h5;
    SET_PEND_I[2] = 1;
    SOFT_TRIG_IDX_I = 5'h1D;
    SOFT_TRIG_WR_I = 1;
    tk(1);
    SET_PEND_I = '0;
    SOFT_TRIG_WR_I = 0;
    chk(PENDING_O, 30'h20000004);
    tk(1);
    chk({REQ_VEC_O, REQ_PRIO_O}, 9'h168);
    clr(29);
    tk(1);
    chk({REQ_VEC_O, REQ_PRIO_O}, 9'h095);
    ENABLE_I[2] = 0;
    tk(1);
    chk(REQ_O, 1'b0);
    ENABLE_I = '1;
    clr(2);
    chk(st(2), 2'h0);
    NMI_LINE_I = 1;
    tk(5);
    chk(NMI_PEND_O, 1'b1);
    chk({REQ_O, REQ_VEC_O}, 7'h42);
    NMI_LINE_I = 0;
    core(1, 6'h02);
    chk({NMI_ACTIVE_O, NMI_PEND_O}, 2'h2);
    core(0, 6'h02);
    chk({NMI_ACTIVE_O, NMI_PEND_O}, 2'h0);
  endtask
  initial
  begin
    tk(4);
    SRST_I = 0;
    chk(PENDING_O | ACTIVE_O, '0);
    tk(3);
    t_level;
    t_pulse;
    t_soft;
    summarize;
  end
endmodule
